//--- core/dadc_top.sv
//Contract
//RQ1: Format high gives two's complement words, low gives offset binary.
//RQ2: Sleep high stops both channels, bias stays; low converts normally.
//RQ3: Power-down high enters full power-down; low operates normally.
//RQ4: Output enable low drives the data bus; high releases it.
//RQ5: Indicator is 1 for first channel word, 0 for second.
//RQ6: Indicator follows converter clock level, lagging it by about 6 ns; code lags it by one 8 ns clk cycle.
//RQ7: Ten three-state data bits, bit 0 least and bit 9 most significant.
//RQ8: One channel word at a time; receiver uses indicator to demultiplex.
//RQ9: Sample on rise; first word 5 rises later, second on following fall.
//RQ10: Power-down with outputs enabled holds the last data on the bus.
//RQ11: Receiver registers each word when data and indicator are stable.
//RQ12: Receiver ignores words after wake-up until pipeline latency passes.
`timescale 1ns/100ps
`include "dadc_params.svh"

module dadc_top #(
  parameter int WORD_W     = `DADC_WORD_W,
  parameter int LATENCY    = `DADC_LATENCY,
  parameter int FIFO_DEPTH = `DADC_FIFO_DEPTH,
  parameter int LAG_CYC    = `DADC_LAG_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Converter clock level, sampled on clk
  input  wire logic                      conv_clk,
  // Quantised sample pairs from the front end
  input  wire logic [WORD_W-1:0]         input_pair_one,
  input  wire logic [WORD_W-1:0]         input_pair_two,
  input  wire logic                      sample_valid,
  output logic                           sample_ready,
  // Control pins
  input  wire logic                      format_twos,
  input  wire logic                      sleep_input,
  input  wire logic                      power_down_input,
  input  wire logic                      out_enable_b,
  // Shared three-state sample bus and channel indicator
  output logic [WORD_W-1:0]              sample_bus_out,
  output logic                           sample_bus_oe,
  output logic                           chan_ind,
  // Register port
  input  wire logic [`DADC_ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata
);
  localparam int PAIR_W = 2 * WORD_W;
  localparam int LVL_W  = $clog2(FIFO_DEPTH) + 1;

  // Word coding: the core works in offset binary
  function automatic logic [WORD_W-1:0] code_word(input logic [WORD_W-1:0] w,
                                                  input logic twos);
    code_word = twos ? {~w[WORD_W-1], w[WORD_W-2:0]} : w;
  endfunction

  // Register decode helper
  function automatic logic addr_is(input logic [`DADC_ADDR_W-1:0] a,
                                   input logic [`DADC_ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction

  dadc_pkg::dadc_power_e power_reg;
  dadc_pkg::dadc_power_e power_next;

  logic [1:0]          ctrl_reg;
  logic                conv_q_reg;
  logic                rise;
  logic                fall;
  logic                fifo_out_valid;
  logic                fifo_pop;
  logic [PAIR_W-1:0]   fifo_out_data;
  logic [LVL_W-1:0]    fifo_level;
  logic [WORD_W-1:0]   pipe_a [0:LATENCY-1];
  logic [WORD_W-1:0]   pipe_b [0:LATENCY-1];
  logic [WORD_W-1:0]   samp_a;
  logic [WORD_W-1:0]   samp_b;
  logic [WORD_W-1:0]   last_a_reg;
  logic [WORD_W-1:0]   last_b_reg;
  logic [WORD_W-1:0]   hold_b_reg;
  logic [WORD_W-1:0]   bus_reg;
  logic                oe_reg;
  logic                underrun_reg;
  logic [31:0]         count_reg;
  logic [31:0]         rdata_reg;
  logic                running;
  logic                lag_hold;
  logic                lag_out;

  // Converter clock edges from the sampled level
  assign rise = conv_clk && !conv_q_reg;
  assign fall = !conv_clk && conv_q_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_q_reg <= 1'b0;
    end else begin
      conv_q_reg <= conv_clk;
    end
  end

  // Power state from pins and software overrides
  always_comb begin
    power_next = dadc_pkg::DADC_RUN;
    // RQ3: full power-down
    if (power_down_input || ctrl_reg[`DADC_CTRL_PDOWN]) begin
      power_next = dadc_pkg::DADC_DOWN;
    // RQ2: sleep disables channels
    end else if (sleep_input || ctrl_reg[`DADC_CTRL_SLEEP]) begin
      power_next = dadc_pkg::DADC_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      power_reg <= dadc_pkg::DADC_RUN;
    end else begin
      case (power_reg)
        dadc_pkg::DADC_RUN: begin
          power_reg <= power_next;
        end
        dadc_pkg::DADC_SLEEP: begin
          power_reg <= power_next;
        end
        dadc_pkg::DADC_DOWN: begin
          power_reg <= power_next;
        end
        default: begin
          power_reg <= dadc_pkg::DADC_RUN;
        end
      endcase
    end
  end

  assign running  = (power_reg == dadc_pkg::DADC_RUN);
  assign lag_hold = (power_reg == dadc_pkg::DADC_DOWN);

  // Input buffer, drained once per converter rise while running
  assign fifo_pop = running && rise && fifo_out_valid;

  dadc_fifo #(
    .WIDTH (PAIR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({input_pair_one, input_pair_two}),
    .out_valid (fifo_out_valid),
    .out_ready (running && rise),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Repeat the last pair when the buffer runs dry
  assign samp_a = fifo_out_valid ? fifo_out_data[PAIR_W-1:WORD_W] : last_a_reg;
  assign samp_b = fifo_out_valid ? fifo_out_data[WORD_W-1:0] : last_b_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_a_reg <= '0;
      last_b_reg <= '0;
    end else if (fifo_pop) begin
      last_a_reg <= samp_a;
      last_b_reg <= samp_b;
    end
  end

  // RQ9: sample on rise, shift latency pipeline
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_a[i] <= '0;
        pipe_b[i] <= '0;
      end
    end else if (running && rise) begin
      pipe_a[0] <= samp_a;
      pipe_b[0] <= samp_b;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_a[i] <= pipe_a[i-1];
        pipe_b[i] <= pipe_b[i-1];
      end
    end
  end

  // Second channel word waits for the falling edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_b_reg <= '0;
    end else if (running && rise) begin
      hold_b_reg <= pipe_b[LATENCY-1];
    end
  end

  // RQ8: one channel word at a time on the bus
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_reg <= '0;
    // RQ10: power-down holds last data
    end else if (power_reg == dadc_pkg::DADC_DOWN) begin
      bus_reg <= bus_reg;
    // RQ9: first word on rise, second on fall
    end else if (running && rise) begin
      // RQ1: output coding
      bus_reg <= code_word(pipe_a[LATENCY-1], format_twos);
    end else if (running && fall) begin
      bus_reg <= code_word(hold_b_reg, format_twos);
    end
  end

  // RQ4: drive enable follows active-low pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= !out_enable_b;
    end
  end

  // RQ7: bit 0 is LSB, bit 9 is MSB
  assign sample_bus_out = bus_reg;
  assign sample_bus_oe  = oe_reg;

  // RQ6: indicator tracks clock level with lag
  dadc_lag #(
    .DEPTH (LAG_CYC)
  ) u_lag (
    .clk   (clk),
    .rst_b (rst_b),
    .hold  (lag_hold),
    .din   (conv_clk),
    .dout  (lag_out)
  );

  // RQ5: high marks first channel word
  assign chan_ind = lag_out;

  // Sticky underrun flag, set wins over the clearing write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      underrun_reg <= 1'b0;
    end else if (running && rise && !fifo_out_valid) begin
      underrun_reg <= 1'b1;
    end else if (reg_wr && addr_is(reg_addr, `DADC_OFF_STATUS)
                 && reg_wdata[`DADC_ST_UNDERRUN]) begin
      underrun_reg <= 1'b0;
    end
  end

  // Converted pair counter, cleared by a write to it; a counting rise wins over the write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (running && rise) begin
      count_reg <= count_reg + 32'h0000_0001;
    end else if (reg_wr && addr_is(reg_addr, `DADC_OFF_COUNT)) begin
      count_reg <= '0;
    end
  end

  // Control register write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= `DADC_CTRL_RESET;
    end else if (reg_wr && addr_is(reg_addr, `DADC_OFF_CTRL)) begin
      ctrl_reg <= reg_wdata[1:0];
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (!reg_rd) begin
      rdata_reg <= '0;
    end else if (addr_is(reg_addr, `DADC_OFF_CTRL)) begin
      rdata_reg <= {30'h0, ctrl_reg};
    end else if (addr_is(reg_addr, `DADC_OFF_STATUS)) begin
      rdata_reg <= '0;
      rdata_reg[`DADC_ST_STATE_LO +: 2]     <= power_reg;
      rdata_reg[`DADC_ST_UNDERRUN]          <= underrun_reg;
      rdata_reg[`DADC_ST_LEVEL_LO +: LVL_W] <= fifo_level;
    end else if (addr_is(reg_addr, `DADC_OFF_COUNT)) begin
      rdata_reg <= count_reg;
    end else if (addr_is(reg_addr, `DADC_OFF_LAST)) begin
      rdata_reg <= {12'h000, last_a_reg, last_b_reg};
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

//--- shared/dadc_params.svh
`ifndef DADC_PARAMS_SVH
`define DADC_PARAMS_SVH

// Converter word and pipeline figures
`define DADC_WORD_W      10
`define DADC_LATENCY     5
`define DADC_FIFO_DEPTH  32

// Indicator lag behind the converter clock level
`define DADC_CLK_PS      8000
`define DADC_LAG_PS      6000
`define DADC_LAG_RAW     (`DADC_LAG_PS / `DADC_CLK_PS)
`define DADC_LAG_CYC     ((`DADC_LAG_RAW < 1) ? 1 : `DADC_LAG_RAW)

// Register offsets (byte addresses)
`define DADC_ADDR_W      4
`define DADC_OFF_CTRL    4'h0
`define DADC_OFF_STATUS  4'h4
`define DADC_OFF_COUNT   4'h8
`define DADC_OFF_LAST    4'hC

// Control register fields and reset value
`define DADC_CTRL_SLEEP  0
`define DADC_CTRL_PDOWN  1
`define DADC_CTRL_RESET  2'h0

// Status register fields
`define DADC_ST_STATE_LO 0
`define DADC_ST_UNDERRUN 2
`define DADC_ST_LEVEL_LO 8

`endif

//--- shared/dadc_pkg.sv
package dadc_pkg;

  // Power state of the converter core
  typedef enum logic [1:0] {
    DADC_RUN   = 2'b00,
    DADC_SLEEP = 2'b01,
    DADC_DOWN  = 2'b10
  } dadc_power_e;

  typedef logic [9:0] dadc_word_t;

endpackage

//--- core/dadc_fifo.sv
`timescale 1ns/100ps
// Sample pair buffer with valid/ready on both sides
module dadc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- core/dadc_lag.sv
`timescale 1ns/100ps
// Delay line for the channel indicator, frozen while hold is high
module dadc_lag #(
  parameter int DEPTH = 1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic hold,
  input  wire logic din,
  output logic      dout
);
  logic [DEPTH-1:0] line_reg;

  assign dout = line_reg[DEPTH-1];

  // Shift the level through DEPTH flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_reg <= '0;
    end else if (!hold) begin
      line_reg <= DEPTH'({line_reg, din});
    end
  end
endmodule

//--- bench/dadc_chk.sv
`timescale 1ns/100ps
// Pin-level checks on the muxed output port, the register read data and sample_ready
module dadc_chk #(
  parameter int WORD_W = 10
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              conv_clk,
  input wire logic              format_twos,
  input wire logic              sleep_input,
  input wire logic              power_down_input,
  input wire logic              out_enable_b,
  input wire logic              sample_ready,
  input wire logic [WORD_W-1:0] sample_bus_out,
  input wire logic              sample_bus_oe,
  input wire logic              chan_ind,
  input wire logic [3:0]        reg_addr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Pin levels held for three cycles, format stable for two
  sequence run_held; !power_down_input [*3]; endsequence
  sequence down_held; power_down_input [*3]; endsequence
  sequence sleep_held; (sleep_input && !power_down_input) [*3]; endsequence
  sequence fmt_held; $stable(format_twos) [*2]; endsequence
  chk_ind_follow: assert property (run_held |-> chan_ind == $past(conv_clk))
    else $error("indicator lag wrong");
  chk_oe_follow: assert property ($past(rst_b) |-> sample_bus_oe == !$past(out_enable_b))
    else $error("drive enable wrong");
  chk_down_freeze: assert property (down_held |-> $stable(sample_bus_out) && $stable(chan_ind))
    else $error("bus moved in power-down");
  chk_sleep_hold: assert property (sleep_held |-> $stable(sample_bus_out))
    else $error("bus moved in sleep");
  chk_bus_with_ind: assert property (fmt_held ##0 $changed(sample_bus_out) |-> $changed(chan_ind))
    else $error("word changed without indicator");
  chk_rdata_idle: assert property ($past(rst_b) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_rd_unmapped: assert property ($past(reg_rd) && ($past(reg_addr) & 4'h3) != 4'h0
    |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
  chk_ready_reset: assert property ($rose(rst_b) |=> sample_ready)
    else $error("buffer not empty after reset");
endmodule

bind dadc_top dadc_chk #(.WORD_W(WORD_W)) u_chk (.*);

//--- bench/dadc_capture.sv
`timescale 1ns/100ps
// Receiver that splits the shared bus into sample pairs
module dadc_capture #(
  parameter int LATENCY = 5
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       restart,
  input  wire logic [9:0] bus_pin,
  input  wire logic       chan_ind,
  output logic [9:0]      word_a,
  output logic [9:0]      word_b,
  output logic            pair_stb
);
  logic       ind_reg;
  logic [3:0] seen_reg;
  // latch on settled indicator edges, drop stale words
  always_ff @(posedge clk) begin
    ind_reg  <= chan_ind;
    pair_stb <= 1'b0;
    if (!rst_b || restart) begin
      seen_reg <= 4'h0;
    end else if (chan_ind && !ind_reg) begin
      word_a <= bus_pin;
      if (seen_reg <= LATENCY) seen_reg <= seen_reg + 4'h1;
    end else if (!chan_ind && ind_reg) begin
      word_b   <= bus_pin;
      pair_stb <= (seen_reg > LATENCY);
    end
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
`include "dadc_params.svh"
module tb;
  typedef struct packed {
    logic       fmt;
    logic [9:0] one, two, exp_a, exp_b;
  } dadc_row_s;
  // Rows: format, input pair, words expected on the bus
  dadc_row_s   rows [4] = '{'{1'b0, 10'h000, 10'h3FF, 10'h000, 10'h3FF},
                           '{1'b0, 10'h155, 10'h2AA, 10'h155, 10'h2AA},
                           '{1'b1, 10'h000, 10'h3FF, 10'h200, 10'h1FF},
                           '{1'b1, 10'h200, 10'h1FF, 10'h000, 10'h3FF}};
  logic        clk = 1'b0, rst_b = 1'b0, conv_clk = 1'b0, restart = 1'b0;
  logic        sample_valid = 1'b0, format_twos = 1'b0, sleep_input = 1'b0;
  logic        power_down_input = 1'b0, out_enable_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0]  input_pair_one = 10'h000, input_pair_two = 10'h000;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [9:0]  sample_bus_out, bus_pin, word_a, word_b;
  logic        sample_ready, sample_bus_oe, chan_ind, pair_stb;
  logic [19:0] got [$];
  int          err_count = 0, num_checks = 0, k;

  dadc_top dut (.*);
  dadc_capture cap (.*);
  // Released bus shows the inverse of its last word
  assign bus_pin = sample_bus_oe ? sample_bus_out : ~sample_bus_out;
  always #4 clk = ~clk;
  // Collect pairs handed over by the receiver
  always @(posedge clk) if (pair_stb === 1'b1) got.push_back({word_a, word_b});

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conv(int n);
    repeat (n) begin
      conv_clk <= 1'b1;
      repeat (2) @(posedge clk);
      conv_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic push(logic [9:0] a, logic [9:0] b);
    input_pair_one <= a;
    input_pair_two <= b;
    sample_valid   <= 1'b1;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] q);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them once settled
    #1;
    q = reg_rdata;
    @(posedge clk);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`DADC_OFF_CTRL, d);
    chk("ctrl", d, 32'h0);
    // One pass per format; the first fills the buffer and overflows it
    for (int f = 0; f < 2; f++) begin
      got.delete();
      format_twos <= f[0];
      foreach (rows[i]) if (rows[i].fmt == f[0]) push(rows[i].one, rows[i].two);
      if (f == 0) begin
        repeat (30) push(10'h0AA, 10'h0AA);
        push(10'h3FF, 10'h3FF);
      end
      sample_valid <= 1'b0;
      restart      <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      chk("ready", sample_ready, f[0]);
      conv(f == 0 ? 40 : 8);
      k = 0;
      foreach (rows[i]) if (rows[i].fmt == f[0]) begin
        chk("pair", got[k], {rows[i].exp_a, rows[i].exp_b});
        k++;
      end
      if (f == 0) begin
        chk("reuse", got[32], {10'h0AA, 10'h0AA});
        rd(`DADC_OFF_STATUS, d);
        chk("underrun", d[2], 1'b1);
      end
    end
    // Sleep from the pin, then from the control register
    sleep_input <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`DADC_OFF_STATUS, d);
    chk("sleep", d[1:0], 2'h1);
    conv(3);
    sleep_input <= 1'b0;
    wr(`DADC_OFF_CTRL, 32'h1);
    rd(`DADC_OFF_STATUS, d);
    chk("soft sleep", d[1:0], 2'h1);
    wr(`DADC_OFF_CTRL, 32'h0);
    // Power-down with outputs enabled, then outputs released
    power_down_input <= 1'b1;
    conv(3);
    rd(`DADC_OFF_STATUS, d);
    chk("down", d[1:0], 2'h2);
    out_enable_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("drive", sample_bus_oe, 1'b0);
    rd(4'h2, d);
    chk("unmapped", d, 32'h0);
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule
